// ### hdl/thp_pkg.sv
package thp_pkg;

  // Queue geometry
  localparam int QUEUE_DEPTH   = 256;
  localparam int PTR_W         = 8;
  localparam int LVL_W         = 9;
  localparam int WORD_W        = 12;
  localparam int FULL_MARGIN   = 8;
  localparam logic [LVL_W-1:0] FULL_LEVEL = 9'h0F7; // Depth less margin, less pin latency

  // Idle fill character K28.5
  localparam logic [WORD_W-1:0] IDLE_WORD = 12'h0BC;

  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG     = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_INT_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_MASK   = 8'h0C;

  // CONFIG fields
  localparam int CFG_CASCADE_TIMING = 0;
  localparam int CFG_QUEUE_BYPASS_N = 1;
  localparam int CFG_ENC_BYPASS_N   = 2;
  localparam logic [2:0] CFG_RESET  = 3'h6;

  // STATUS fields
  localparam int STS_LEVEL_LSB = 0;
  localparam int STS_FULL      = 9;
  localparam int STS_HALTED    = 10;

  // Interrupt bits
  localparam int INT_FULL_RISE = 0;
  localparam int INT_OVERFLOW  = 1;
  localparam int INT_CELL_STOP = 2;
  localparam int INT_W         = 3;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 3'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Character kind
  typedef enum logic [1:0] {KIND_DATA, KIND_SPECIAL, KIND_VIOLATION, KIND_RAW} thp_kind_t;

  // Queue entry
  typedef struct packed {
    logic              soc;
    thp_kind_t         kind;
    logic [WORD_W-1:0] word;
  } thp_entry_t;

  // Pacing state
  typedef enum logic {ST_RUN, ST_HALTED} thp_state_t;

endpackage : thp_pkg

// ### hdl/thp_queue_if.sv
`timescale 1ns/100ps
interface thp_queue_if;
  import thp_pkg::*;
  logic                   push;
  thp_entry_t             push_entry;
  logic                   pop;
  thp_entry_t             head;
  logic                   not_empty;
  logic [LVL_W-1:0]       level;
  modport owner (output push, push_entry, pop, input head, not_empty, level);
  modport store (input push, push_entry, pop, output head, not_empty, level);
endinterface : thp_queue_if

// ### hdl/thp_tx_queue.sv
`timescale 1ns/100ps
module thp_tx_queue (
  // Clock and reset
  input wire logic    clk,
  input wire logic    rst,
  // Queue access
  thp_queue_if.store  q
);
  import thp_pkg::*;

  thp_entry_t       mem [QUEUE_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [LVL_W-1:0] level;
  logic             do_push;
  logic             do_pop;

  // Qualify against occupancy
  assign do_push = q.push && (level != LVL_W'(QUEUE_DEPTH));
  assign do_pop  = q.pop && (level != '0);

  // Storage array
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= q.push_entry;
    end
  end

  // Pointers
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + PTR_W'(1);
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + PTR_W'(1);
      end
    end
  end

  // Occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= '0;
    end else if (do_push && !do_pop) begin
      level <= level + LVL_W'(1);
    end else if (do_pop && !do_push) begin
      level <= level - LVL_W'(1);
    end
  end

  assign q.head      = mem[rd_ptr];
  assign q.not_empty = (level != '0);
  assign q.level     = level;

endmodule : thp_tx_queue

// ### hdl/thp_tx_host_write_port.sv
`timescale 1ns/100ps
// Contract
// - Decode select, violation into character type, cell-start kept as its own mark
// - Encoder bypassed: ignore special-or-data select
// - Write taken only while qualifier active, polarity per timing
// - Stop released: queued characters flow without pause once running; a slot in the cycle a halt ends still sends idle
// - Stop asserted: send until cell-start, then halt
// - Brief stop release sends exactly one cell
// - Stopped or empty: send K28.5 idle fill
// - Queue bypassed: stop input ignored
// - Queue inputs sampled on rising clock edges
// - Full flag polarity per timing, registered
// - Host marks first character of each packet
// - Eight more writes accepted after full asserts
module thp_tx_host_write_port (
  // Clock and reset
  input  wire logic                       SYS_CLK,
  input  wire logic                       RST,
  // AXI4-Lite write channels
  input  wire logic [7:0]                 S_AXI_AWADDR,
  input  wire logic                       S_AXI_AWVALID,
  output      logic                       S_AXI_AWREADY,
  input  wire logic [31:0]                S_AXI_WDATA,
  input  wire logic [3:0]                 S_AXI_WSTRB,
  input  wire logic                       S_AXI_WVALID,
  output      logic                       S_AXI_WREADY,
  output      logic [1:0]                 S_AXI_BRESP,
  output      logic                       S_AXI_BVALID,
  input  wire logic                       S_AXI_BREADY,
  // AXI4-Lite read channels
  input  wire logic [7:0]                 S_AXI_ARADDR,
  input  wire logic                       S_AXI_ARVALID,
  output      logic                       S_AXI_ARREADY,
  output      logic [31:0]                S_AXI_RDATA,
  output      logic [1:0]                 S_AXI_RRESP,
  output      logic                       S_AXI_RVALID,
  input  wire logic                       S_AXI_RREADY,
  // Host write port
  input  wire logic [thp_pkg::WORD_W-1:0] TX_PARALLEL_WORD,
  input  wire logic                       TX_WRITE_QUALIFIER,
  input  wire logic                       TX_SPECIAL_OR_DATA_SELECT,
  input  wire logic                       TX_VIOLATION_SYMBOL_REQUEST,
  input  wire logic                       TX_CELL_START_MARK,
  input  wire logic                       TX_HOLD_AT_CELL_BOUNDARY_N,
  output      logic                       TX_QUEUE_FULL_FLAG,
  // Transmitter side
  input  wire logic                       TX_CHAR_REQUEST,
  output      logic [thp_pkg::WORD_W-1:0] TX_CHAR_WORD,
  output      thp_pkg::thp_kind_t         TX_CHAR_KIND,
  output      logic                       TX_CHAR_SOC,
  output      logic                       TX_CHAR_STROBE,
  // Interrupt
  output      logic                       IRQ
);
  import thp_pkg::*;

  thp_queue_if q ();

  // Configuration and interrupt registers
  logic                   cascade_timing;
  logic                   queue_bypass_n;
  logic                   encoder_bypass_n;
  logic [INT_W-1:0]       int_status;
  logic [INT_W-1:0]       int_mask;
  logic [INT_W-1:0]       int_event;
  logic [INT_W-1:0]       int_clear;

  // AXI bookkeeping
  logic                   aw_held;
  logic [7:0]             aw_addr;
  logic                   w_held;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   wr_fire;
  logic                   wr_hit;
  logic [31:0]            rd_value;
  logic                   rd_hit;

  // Core state
  thp_state_t             state;
  thp_state_t             next_state;
  logic                   sent_any;
  logic                   wr_active;
  logic                   accept;
  logic                   overflow;
  logic                   full_int;
  logic                   full_prev;
  logic                   pop;
  logic                   at_boundary;
  thp_kind_t              next_kind;

  thp_tx_queue u_queue (
    .clk (SYS_CLK),
    .rst (RST),
    .q   (q.store)
  );

  // Write address channel
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
  assign wr_fire       = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // Write data channel
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Write address decode
  assign wr_hit = (aw_addr == OFS_CONFIG) || (aw_addr == OFS_STATUS) ||
                  (aw_addr == OFS_INT_STATUS) || (aw_addr == OFS_INT_MASK);

  // Write response
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Configuration register, low byte only
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      {encoder_bypass_n, queue_bypass_n, cascade_timing} <= CFG_RESET;
    end else if (wr_fire && aw_addr == OFS_CONFIG && w_strb[0]) begin
      cascade_timing   <= w_data[CFG_CASCADE_TIMING];
      queue_bypass_n   <= w_data[CFG_QUEUE_BYPASS_N];
      encoder_bypass_n <= w_data[CFG_ENC_BYPASS_N];
    end
  end

  // Interrupt mask register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      int_mask <= INT_MASK_RESET;
    end else if (wr_fire && aw_addr == OFS_INT_MASK && w_strb[0]) begin
      int_mask <= w_data[INT_W-1:0];
    end
  end

  // Sticky status, set beats write-one-to-clear
  assign int_clear = (wr_fire && aw_addr == OFS_INT_STATUS && w_strb[0]) ?
                     w_data[INT_W-1:0] : '0;
  assign int_event = {(state == ST_RUN && next_state == ST_HALTED), overflow,
                      (full_int && !full_prev)};

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status & ~int_clear) | int_event;
    end
  end

  // Level interrupt output
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(((int_status & ~int_clear) | int_event) & int_mask);
    end
  end

  // Read decode
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    unique case (S_AXI_ARADDR)
      OFS_CONFIG: rd_value[2:0] = {encoder_bypass_n, queue_bypass_n, cascade_timing};
      OFS_STATUS: begin
        rd_value[STS_LEVEL_LSB +: LVL_W] = q.level;
        rd_value[STS_FULL]               = full_int;
        rd_value[STS_HALTED]             = (state == ST_HALTED);
      end
      OFS_INT_STATUS: rd_value[INT_W-1:0] = int_status;
      OFS_INT_MASK:   rd_value[INT_W-1:0] = int_mask;
      default:        rd_hit = 1'b0;
    endcase
  end

  // Read channel
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_value;
      S_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Write qualifier polarity by timing mode
  assign wr_active = cascade_timing ? TX_WRITE_QUALIFIER : !TX_WRITE_QUALIFIER;
  assign accept    = wr_active && (q.level != LVL_W'(QUEUE_DEPTH));
  assign overflow  = wr_active && !accept;

  // Character type decode, violation over special over data
  assign next_kind = !encoder_bypass_n          ? KIND_RAW :
                     TX_VIOLATION_SYMBOL_REQUEST ? KIND_VIOLATION :
                     TX_SPECIAL_OR_DATA_SELECT   ? KIND_SPECIAL :
                                                   KIND_DATA;

  // Push into queue on the sampling edge
  assign q.push       = accept;
  assign q.push_entry = {TX_CELL_START_MARK, next_kind, TX_PARALLEL_WORD};

  // Threshold one below margin, as the pin lags the level by a cycle
  assign full_int = queue_bypass_n ? (q.level >= FULL_LEVEL) : q.not_empty;

  // Full flag pin, polarity by timing mode, and its rise detector
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      full_prev          <= 1'b0;
      TX_QUEUE_FULL_FLAG <= 1'b1;
    end else begin
      full_prev          <= full_int;
      TX_QUEUE_FULL_FLAG <= cascade_timing ? full_int : !full_int;
    end
  end

  // Boundary seen at head, except after a halt until one character has been sent
  assign at_boundary = q.not_empty && q.head.soc && sent_any;

  // Pacing state transitions
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (queue_bypass_n && !TX_HOLD_AT_CELL_BOUNDARY_N && at_boundary) begin
          next_state = ST_HALTED;
        end
      end
      ST_HALTED: begin
        if (TX_HOLD_AT_CELL_BOUNDARY_N || !queue_bypass_n) begin
          next_state = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Pop a queued character on each character slot while running and not about to halt
  assign pop   = TX_CHAR_REQUEST && q.not_empty && state == ST_RUN && next_state == ST_RUN;
  assign q.pop = pop;

  // Marks that a halt cannot fire on the cell just released
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sent_any <= 1'b1;
    end else if (state == ST_HALTED) begin
      sent_any <= 1'b0;
    end else if (pop) begin
      sent_any <= 1'b1;
    end
  end

  // Character output, idle fill when nothing to send
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      TX_CHAR_WORD   <= IDLE_WORD;
      TX_CHAR_KIND   <= KIND_SPECIAL;
      TX_CHAR_SOC    <= 1'b0;
      TX_CHAR_STROBE <= 1'b0;
    end else begin
      TX_CHAR_STROBE <= TX_CHAR_REQUEST;
      if (pop) begin
        TX_CHAR_WORD <= q.head.word;
        TX_CHAR_KIND <= q.head.kind;
        TX_CHAR_SOC  <= q.head.soc;
      end else if (TX_CHAR_REQUEST) begin
        TX_CHAR_WORD <= IDLE_WORD;
        TX_CHAR_KIND <= KIND_SPECIAL;
        TX_CHAR_SOC  <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  property p_write_qual;
    (wr_active && q.level < LVL_W'(QUEUE_DEPTH)) |=>
      q.level == $past(q.level) + LVL_W'(!$past(pop));
  endproperty
  a_write_qual: assert property (p_write_qual) else $error("qualified write lost");
  property p_no_write_unqual;
    (!wr_active && !pop) |=> q.level == $past(q.level);
  endproperty
  a_no_write_unqual: assert property (p_no_write_unqual) else $error("unqualified write");
  property p_full_pin;
    ##1 TX_QUEUE_FULL_FLAG == ($past(cascade_timing) ? $past(full_int) : !$past(full_int));
  endproperty
  a_full_pin: assert property (p_full_pin) else $error("full flag polarity wrong");
  property p_full_margin;
    (queue_bypass_n && full_int && !full_prev) |->
      (LVL_W'(QUEUE_DEPTH) - q.level) > LVL_W'(FULL_MARGIN);
  endproperty
  a_full_margin: assert property (p_full_margin) else $error("full raised too late");
  property p_idle_fill;
    (TX_CHAR_REQUEST && !pop) |=>
      TX_CHAR_STROBE && TX_CHAR_WORD == IDLE_WORD && TX_CHAR_KIND == KIND_SPECIAL;
  endproperty
  a_idle_fill: assert property (p_idle_fill) else $error("idle fill missing");
  property p_halt_stops;
    (state == ST_HALTED && !TX_HOLD_AT_CELL_BOUNDARY_N && queue_bypass_n && TX_CHAR_REQUEST) |=>
      TX_CHAR_WORD == IDLE_WORD && !TX_CHAR_SOC;
  endproperty
  a_halt_stops: assert property (p_halt_stops) else $error("sent while halted");
  property p_run_flows;
    (state == ST_RUN && TX_HOLD_AT_CELL_BOUNDARY_N && q.not_empty && TX_CHAR_REQUEST) |-> pop;
  endproperty
  a_run_flows: assert property (p_run_flows) else $error("paused while stop released");
  property p_bypass_ignores_stop;
    (!queue_bypass_n && q.not_empty && TX_CHAR_REQUEST && state == ST_RUN) |-> pop;
  endproperty
  a_bypass_ignores_stop: assert property (p_bypass_ignores_stop) else $error("stop obeyed");
  property p_raw_kind;
    (!encoder_bypass_n && TX_SPECIAL_OR_DATA_SELECT) |-> q.push_entry.kind == KIND_RAW;
  endproperty
  a_raw_kind: assert property (p_raw_kind) else $error("select used in encoder bypass");
  property p_boundary_halt;
    (state == ST_RUN && queue_bypass_n && !TX_HOLD_AT_CELL_BOUNDARY_N && at_boundary) |=>
      state == ST_HALTED ##1 !pop;
  endproperty
  a_boundary_halt: assert property (p_boundary_halt) else $error("no halt at cell start");

endmodule : thp_tx_host_write_port

// ### tb/thp_host_model.sv
`timescale 1ns/100ps
module thp_host_model
  import thp_pkg::*;
(
  // Clock and control
  input  wire logic              clk,
  input  wire logic              cascade,
  input  wire logic              ign_full,
  input  wire logic              go,
  input  wire logic [8:0]        count,
  input  wire logic [11:0]       base,
  input  wire logic [8:0]        pkt,
  input  wire logic              sel,
  input  wire logic              viol,
  input  wire logic              full_flag,
  // Host pins
  output      logic [WORD_W-1:0] word,
  output      logic              qual,
  output      logic              sel_o,
  output      logic              viol_o,
  output      logic              soc,
  output      logic              busy
);
  logic [8:0] sent;
  logic [8:0] pos;
  logic       full_on;

  // Idle before the first edge
  initial begin
    busy = 1'b0;
    qual = 1'b1;
    word = '0;
    soc = 1'b0;
    sel_o = 1'b0;
    viol_o = 1'b0;
  end

  // Full flag polarity follows timing mode
  assign full_on = cascade ? full_flag : !full_flag;

  // One word per edge; released lines toggle so stale values never match
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      sent <= '0;
      pos <= '0;
    end
    if (busy && sent < count && (ign_full || !full_on)) begin
      word <= base + 12'(sent);
      qual <= cascade;
      soc <= (pos == 9'h0);
      sel_o <= sel;
      viol_o <= viol;
      sent <= sent + 9'h1;
      pos <= (pos + 9'h1 == pkt) ? 9'h0 : pos + 9'h1;
    end else begin
      qual <= !cascade;
      word <= ~word;
      soc <= !soc;
      sel_o <= !sel_o;
      viol_o <= !viol_o;
      if (busy && sent == count) busy <= 1'b0;
    end
  end
endmodule : thp_host_model

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import thp_pkg::*;
  // Bench signals
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, req, hold_n;
  logic        cascade, ign, go, sel, viol, h_qual, h_sel, h_viol, h_soc, busy;
  logic        full, c_soc, strobe, irq, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [8:0]  count, pkt;
  logic [11:0] base, h_word, c_word;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, r;
  thp_kind_t   c_kind;
  int          err_count, comparisons;

  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  thp_tx_host_write_port u_thp_tx_host_write_port (
    .SYS_CLK(clk), .RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .TX_PARALLEL_WORD(h_word), .TX_WRITE_QUALIFIER(h_qual),
    .TX_SPECIAL_OR_DATA_SELECT(h_sel), .TX_VIOLATION_SYMBOL_REQUEST(h_viol),
    .TX_CELL_START_MARK(h_soc), .TX_HOLD_AT_CELL_BOUNDARY_N(hold_n),
    .TX_QUEUE_FULL_FLAG(full), .TX_CHAR_REQUEST(req), .TX_CHAR_WORD(c_word),
    .TX_CHAR_KIND(c_kind), .TX_CHAR_SOC(c_soc), .TX_CHAR_STROBE(strobe), .IRQ(irq));

  thp_host_model u_thp_host_model (
    .clk(clk), .cascade(cascade), .ign_full(ign), .go(go), .count(count),
    .base(base), .pkt(pkt), .sel(sel), .viol(viol), .full_flag(full),
    .word(h_word), .qual(h_qual), .sel_o(h_sel), .viol_o(h_viol),
    .soc(h_soc), .busy(busy));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Register write, channels released as taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_go, w_go, b_go;
    int n;
    n = 0;
    b_go = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_go && n < 40) begin
      @(negedge clk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid;
      r = bresp;
      @(posedge clk);
      n++;
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      if (aw_go && a == OFS_CONFIG) cascade <= d[CFG_CASCADE_TIMING];
    end
    bready <= 1'b0;
    chk({31'h0, b_go}, 32'h0000_0001);
  endtask : axi_wr

  // Register read
  task automatic axi_rd(input logic [7:0] a);
    bit ar_go, r_go;
    int n;
    n = 0;
    r_go = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_go && n < 40) begin
      @(negedge clk);
      ar_go = arvalid && arready;
      r_go = rvalid;
      v = rdata;
      r = rresp;
      @(posedge clk);
      n++;
      if (ar_go) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk({31'h0, r_go}, 32'h0000_0001);
  endtask : axi_rd

  // One character slot of the transmitter
  task automatic pull(input logic [11:0] w, input thp_kind_t k, input logic s);
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    chk({16'h0, strobe, c_soc, c_kind, c_word}, {16'h0, 1'b1, s, k, w});
  endtask : pull

  task automatic host(input int n, input logic [11:0] b, input int p, input logic s,
                      input logic vi);
    @(posedge clk);
    count <= 9'(n);
    base <= b;
    pkt <= 9'(p);
    sel <= s;
    viol <= vi;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : host

  task automatic host_wait();
    int n;
    n = 0;
    @(negedge clk);
    while (busy && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, busy}, 32'h0000_0000);
  endtask : host_wait

  task automatic t_reset();
    axi_rd(OFS_CONFIG);
    chk(v, {29'h0, CFG_RESET});
    axi_rd(OFS_INT_MASK);
    chk(v, 32'h0000_0000);
    axi_rd(8'h10);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(8'h20, 32'h0000_0001);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk({31'h0, full}, 32'h0000_0001);
    pull(IDLE_WORD, KIND_SPECIAL, 1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_flow();
    host(5, 12'h100, 5, 1'b0, 1'b0);
    host_wait();
    for (int i = 0; i < 5; i++) pull(12'h100 + 12'(i), KIND_DATA, i == 0);
    pull(IDLE_WORD, KIND_SPECIAL, 1'b0);
    $display("test flow done");
  endtask : t_flow

  task automatic t_kind();
    for (int i = 0; i < 4; i++) begin
      host(1, 12'h0A0 + 12'(i), 1, i[0], i[1]);
      host_wait();
      pull(12'h0A0 + 12'(i), i[1] ? KIND_VIOLATION : (i[0] ? KIND_SPECIAL : KIND_DATA), 1'b1);
    end
    axi_wr(OFS_CONFIG, 32'h0000_0002);
    host(1, 12'h3FF, 1, 1'b1, 1'b0);
    host_wait();
    pull(12'h3FF, KIND_RAW, 1'b1);
    axi_wr(OFS_CONFIG, 32'h0000_0006);
    $display("test kind done");
  endtask : t_kind

  task automatic t_stop();
    host(9, 12'h200, 3, 1'b0, 1'b0);
    host_wait();
    pull(12'h200, KIND_DATA, 1'b1);
    pull(12'h201, KIND_DATA, 1'b0);
    @(posedge clk) hold_n <= 1'b0;
    pull(12'h202, KIND_DATA, 1'b0);
    pull(IDLE_WORD, KIND_SPECIAL, 1'b0);
    axi_rd(OFS_STATUS);
    chk({31'h0, v[STS_HALTED]}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    @(posedge clk) hold_n <= 1'b1;
    @(posedge clk) hold_n <= 1'b0;
    for (int i = 3; i < 6; i++) pull(12'h200 + 12'(i), KIND_DATA, i == 3);
    pull(IDLE_WORD, KIND_SPECIAL, 1'b0);
    @(posedge clk) hold_n <= 1'b1;
    for (int i = 6; i < 9; i++) pull(12'h200 + 12'(i), KIND_DATA, i == 6);
    axi_rd(OFS_INT_STATUS);
    chk({31'h0, v[INT_CELL_STOP]}, 32'h0000_0001);
    axi_wr(OFS_INT_STATUS, 32'h0000_0007);
    $display("test stop done");
  endtask : t_stop

  task automatic t_full();
    axi_wr(OFS_INT_MASK, 32'h0000_0003);
    axi_wr(OFS_CONFIG, 32'h0000_0007);
    @(negedge clk);
    chk({31'h0, full}, 32'h0000_0000);
    host(256, 12'h000, 256, 1'b0, 1'b0);
    repeat (300) @(posedge clk);
    @(negedge clk);
    chk({31'h0, full}, 32'h0000_0001);
    axi_rd(OFS_STATUS);
    chk({31'h0, v[8:0] <= 9'h0F9}, 32'h0000_0001);
    axi_rd(OFS_INT_STATUS);
    chk({30'h0, v[1:0]}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    @(posedge clk) ign <= 1'b1;
    host_wait();
    axi_rd(OFS_STATUS);
    chk({21'h0, v[10:0]}, 32'h0000_0300);
    axi_rd(OFS_INT_STATUS);
    chk({31'h0, v[INT_OVERFLOW]}, 32'h0000_0000);
    host(1, 12'hFFF, 1, 1'b0, 1'b0);
    host_wait();
    axi_rd(OFS_INT_STATUS);
    chk({31'h0, v[INT_OVERFLOW]}, 32'h0000_0001);
    @(posedge clk) ign <= 1'b0;
    for (int i = 0; i < 256; i++) pull(12'(i), KIND_DATA, i == 0);
    pull(IDLE_WORD, KIND_SPECIAL, 1'b0);
    chk({31'h0, full}, 32'h0000_0000);
    axi_wr(OFS_INT_STATUS, 32'h0000_0007);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    axi_wr(OFS_CONFIG, 32'h0000_0006);
    $display("test full done");
  endtask : t_full

  task automatic t_bypass();
    axi_wr(OFS_CONFIG, 32'h0000_0004);
    @(posedge clk) hold_n <= 1'b0;
    host(1, 12'h3A5, 1, 1'b0, 1'b0);
    host_wait();
    pull(12'h3A5, KIND_DATA, 1'b1);
    @(posedge clk) hold_n <= 1'b1;
    axi_wr(OFS_CONFIG, 32'h0000_0006);
    $display("test bypass done");
  endtask : t_bypass

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, req} = 7'h40;
    {hold_n, cascade, ign, go, sel, viol} = 6'h20;
    {awaddr, araddr, wdata, count, pkt, base} = '0;
    err_count = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_flow();
    t_kind();
    t_stop();
    t_full();
    t_bypass();
    test_done();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule : testbench
